// *** twoc_pkg.sv ***
`default_nettype none
package twoc_pkg;
  // Register word indices, byte address is four times these
  localparam logic [7:0] IDX_CTRL_A = 8'ha0;
  localparam logic [7:0] IDX_CTRL_B = 8'ha1;
  localparam logic [7:0] IDX_STATUS = 8'haf;
  // Reset value and writable bits
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] CTRL_B_WMASK = 8'hdf;
  // Field positions
  localparam int A_OM_A_HI = 7;
  localparam int A_OM_A_LO = 6;
  localparam int A_OM_B_HI = 5;
  localparam int A_OM_B_LO = 4;
  localparam int A_WM_HI = 1;
  localparam int A_WM_LO = 0;
  localparam int B_WM_HI = 4;
  localparam int B_WM_LO = 3;
  localparam int B_CS_HI = 2;
  localparam int B_CS_LO = 0;
  // Output-mode field codes
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  // Waveform mode codes that the toggle option and the table need
  localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
  localparam logic [3:0] MODE_PC_CMPA = 4'hb;
  localparam logic [3:0] MODE_FAST_CAP = 4'he;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hf;
  // Fixed TOP values
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  // Counting family
  typedef enum logic [2:0] {
    FAM_NORMAL = 3'h0, FAM_CTC = 3'h1, FAM_FAST = 3'h2,
    FAM_PC = 3'h3, FAM_PFC = 3'h4, FAM_RSVD = 3'h5
  } twoc_family_t;
  // Where TOP comes from
  typedef enum logic [1:0] {
    TSRC_FIXED = 2'h0, TSRC_CMPA = 2'h1, TSRC_CAPT = 2'h2
  } twoc_tsrc_t;
  // Compare update point and overflow flag point
  typedef enum logic [1:0] {
    PT_IMMED = 2'h0, PT_TOP = 2'h1, PT_BOTTOM = 2'h2, PT_MAX = 2'h3
  } twoc_point_t;
  // Decoded mode, handed to the counter datapath
  typedef struct packed {
    twoc_family_t family;
    twoc_tsrc_t top_src;
    logic [15:0] top_fixed;
    twoc_point_t upd_at;
    twoc_point_t ovf_at;
  } twoc_mode_t;
  // Events from the counter datapath, index 0 is channel A
  typedef struct packed {
    logic at_bottom;
    logic count_up;
    logic [1:0] match;
    logic [1:0] cmp_eq_top;
  } twoc_evt_t;
endpackage : twoc_pkg
`default_nettype wire

// *** twoc_wave_ctrl.sv ***
// Added by the designer: register access over Wishbone.
`default_nettype none
// Function
// RULE_01 - Nonzero output mode routes compare onto pin
// RULE_02 - Software sets direction bit to drive pin
// RULE_03 - Channel B also needs port D bit two
// RULE_04 - Non-PWM: off, toggle, clear, set on match
// RULE_05 - Fast PWM: match and bottom set/clear
// RULE_06 - Fast PWM toggle only A, modes 14/15
// RULE_07 - Fast PWM: ignore match at TOP, keep bottom
// RULE_08 - Phase PWM: up and down match actions
// RULE_09 - Phase PWM toggle only A, modes 9/11
// RULE_10 - Mode built from both control registers
// RULE_11 - Modes 0, 4, 12: normal and CLEAR_ON_MATCH_MODE decode
// RULE_12 - Modes 1-3: phase correct fixed TOP
// RULE_13 - Modes 5-7, 14, 15: fast PWM decode
// RULE_14 - Modes 8, 9: phase-frequency correct decode
// RULE_15 - Modes 10, 11: phase correct variable TOP
// RULE_16 - High mode bits at control B bits 3-4
// RULE_17 - Software avoids reserved mode 13
// RULE_18 - Control A bits 3, 2 read zero
module twoc_wave_ctrl (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // Wishbone classic slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [9:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Counter datapath events, same clock
  input wire twoc_pkg::twoc_evt_t CNT_EVT_IN,
  // Port function underneath the compare outputs, same clock
  input wire logic [1:0] PORT_DATA_IN,
  input wire logic [1:0] PORT_DIR_IN,
  input wire logic PORT_D_BIT_TWO_IN,
  input wire logic MODULATOR_EN_IN,
  // Decoded mode towards the counter datapath
  output twoc_pkg::twoc_mode_t MODE_INFO_OUT,
  output logic [2:0] CLK_SEL_OUT,
  // Compare outputs and pins
  output logic [1:0] CMP_OUT_OUT,
  output logic [1:0] PIN_OVR_OUT,
  output logic [1:0] PIN_OUT,
  output logic [1:0] PIN_OE_OUT
);

  // Control registers
  // Both reset to zero: timer off, pins released
  logic [7:0] wave_ctrl_a_ff;
  logic [7:0] wave_ctrl_b_ff;
  // Bus answer registers
  // Read data is held until the next access
  logic ack_ff;
  logic [31:0] rdata_ff;
  // Registered outputs
  // Pin state is kept per channel, index 0 is channel A
  twoc_pkg::twoc_mode_t mode_info_ff;
  logic [1:0] wave_ff;
  logic [1:0] ovr_ff;
  logic [1:0] pin_ff;
  logic [1:0] pin_oe_ff;

  // Bus decode
  // One access is taken per request: a high ack blocks a second take
  // while the master still holds the same request on the bus.
  // Only the low data lane carries register bits, so SEL[0] gates writes.
  // Unmapped words are still answered, so the master never hangs.
  // Word index is the byte address without its two low bits
  wire logic [7:0] bus_idx = WB_ADR_IN[9:2];
  // Request seen and not yet answered
  wire logic bus_req = WB_CYC_IN & WB_STB_IN & ~ack_ff;
  wire logic bus_wr = bus_req & WB_WE_IN & WB_SEL_IN[0];
  wire logic hit_a = bus_idx == twoc_pkg::IDX_CTRL_A;
  wire logic hit_b = bus_idx == twoc_pkg::IDX_CTRL_B;
  wire logic hit_st = bus_idx == twoc_pkg::IDX_STATUS;
  wire logic wr_a = bus_wr & hit_a;
  wire logic wr_b = bus_wr & hit_b;

  // Masking at write time keeps the read path a plain selection
  // Control B bit 5 has no storage either
  // Unimplemented bits are masked on write so they always read zero
  wire logic [7:0] nxt_wave_ctrl_a = WB_DAT_IN[7:0] & twoc_pkg::CTRL_A_WMASK; // [RULE_18]
  wire logic [7:0] nxt_wave_ctrl_b = WB_DAT_IN[7:0] & twoc_pkg::CTRL_B_WMASK; // [RULE_16]

  // Output-mode fields per channel
  // Indexed copy lets the channel loop pick its own field
  wire logic [1:0] chan_a_outmode = {wave_ctrl_a_ff[twoc_pkg::A_OM_A_HI], wave_ctrl_a_ff[twoc_pkg::A_OM_A_LO]};
  wire logic [1:0] chan_b_outmode = {wave_ctrl_a_ff[twoc_pkg::A_OM_B_HI], wave_ctrl_a_ff[twoc_pkg::A_OM_B_LO]};
  wire logic [1:0] outmode [2];
  assign outmode[0] = chan_a_outmode;
  assign outmode[1] = chan_b_outmode;

  // Four-bit waveform mode from both registers
  // Low pair sits in control A, high pair in control B
  // A write to either register changes the mode at once
  wire logic wave_mode_bit3 = wave_ctrl_b_ff[twoc_pkg::B_WM_HI]; // [RULE_16]
  wire logic wave_mode_bit2 = wave_ctrl_b_ff[twoc_pkg::B_WM_LO]; // [RULE_16]
  wire logic wave_mode_bit1 = wave_ctrl_a_ff[twoc_pkg::A_WM_HI];
  wire logic wave_mode_bit0 = wave_ctrl_a_ff[twoc_pkg::A_WM_LO];
  wire logic [3:0] wave_mode_sel = {wave_mode_bit3, wave_mode_bit2, wave_mode_bit1, wave_mode_bit0}; // [RULE_10]

  // Mode table decode
  // Defaults describe the reserved code; each listed mode overrides only the fields it changes
  // Family, TOP source, update point and flag point travel together
  twoc_pkg::twoc_mode_t nxt_mode;
  always_comb begin
    nxt_mode.family = twoc_pkg::FAM_RSVD;
    nxt_mode.top_src = twoc_pkg::TSRC_FIXED;
    nxt_mode.top_fixed = twoc_pkg::TOP_MAX;
    nxt_mode.upd_at = twoc_pkg::PT_IMMED;
    nxt_mode.ovf_at = twoc_pkg::PT_MAX;
    unique case (wave_mode_sel)
      // Normal: free count up to the full 16-bit TOP
      4'h0: begin
        nxt_mode.family = twoc_pkg::FAM_NORMAL; // [RULE_11]
      end
      // Phase correct with fixed 8, 9 or 10-bit TOP
      4'h1, 4'h2, 4'h3: begin
        nxt_mode.family = twoc_pkg::FAM_PC; // [RULE_12]
        nxt_mode.upd_at = twoc_pkg::PT_TOP;
        nxt_mode.ovf_at = twoc_pkg::PT_BOTTOM;
      end
      4'h4, 4'hc: begin
        // CLEAR_ON_MATCH_MODE, TOP from compare A or capture
        nxt_mode.family = twoc_pkg::FAM_CTC; // [RULE_11]
        nxt_mode.top_src = wave_mode_bit3 ? twoc_pkg::TSRC_CAPT : twoc_pkg::TSRC_CMPA;
      end
      // Fast PWM; bit 3 selects a register TOP
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: begin
        nxt_mode.family = twoc_pkg::FAM_FAST; // [RULE_13]
        nxt_mode.upd_at = twoc_pkg::PT_BOTTOM;
        nxt_mode.ovf_at = twoc_pkg::PT_TOP;
        if (wave_mode_bit3) begin
          nxt_mode.top_src = wave_mode_bit0 ? twoc_pkg::TSRC_CMPA : twoc_pkg::TSRC_CAPT;
        end
      end
      // Phase and frequency correct, register TOP
      4'h8, 4'h9: begin
        nxt_mode.family = twoc_pkg::FAM_PFC; // [RULE_14]
        nxt_mode.top_src = wave_mode_bit0 ? twoc_pkg::TSRC_CMPA : twoc_pkg::TSRC_CAPT;
        nxt_mode.upd_at = twoc_pkg::PT_BOTTOM;
        nxt_mode.ovf_at = twoc_pkg::PT_BOTTOM;
      end
      // Phase correct, register TOP
      4'ha, 4'hb: begin
        nxt_mode.family = twoc_pkg::FAM_PC; // [RULE_15]
        nxt_mode.top_src = wave_mode_bit0 ? twoc_pkg::TSRC_CMPA : twoc_pkg::TSRC_CAPT;
        nxt_mode.upd_at = twoc_pkg::PT_TOP;
        nxt_mode.ovf_at = twoc_pkg::PT_BOTTOM;
      end
      4'hd: begin
        // Reserved code: compare outputs frozen, both channels handed back to port data
        nxt_mode.family = twoc_pkg::FAM_RSVD; // [RULE_17]
      end
    endcase
    // Fixed TOP width follows the two low mode bits in the fixed modes
    // Register-TOP modes keep the default fixed value, which is unused
    if (nxt_mode.top_src == twoc_pkg::TSRC_FIXED) begin
      unique case (wave_mode_sel[1:0])
        2'h1: nxt_mode.top_fixed = twoc_pkg::TOP_8BIT; // [RULE_12] [RULE_13]
        2'h2: nxt_mode.top_fixed = twoc_pkg::TOP_9BIT;
        2'h3: nxt_mode.top_fixed = twoc_pkg::TOP_10BIT;
        2'h0: nxt_mode.top_fixed = twoc_pkg::TOP_MAX; // [RULE_11]
      endcase
    end
  end

  // Family flags
  // The reserved code falls in none of the three groups
  wire logic fam_nonpwm = (nxt_mode.family == twoc_pkg::FAM_NORMAL) | (nxt_mode.family == twoc_pkg::FAM_CTC);
  wire logic fam_fast = nxt_mode.family == twoc_pkg::FAM_FAST;
  wire logic fam_phase = (nxt_mode.family == twoc_pkg::FAM_PC) | (nxt_mode.family == twoc_pkg::FAM_PFC);
  // Modes in which channel A may toggle under PWM
  // Checked against the full code, not only the family
  wire logic fast_tgl_ok = (wave_mode_sel == twoc_pkg::MODE_FAST_CAP) | (wave_mode_sel == twoc_pkg::MODE_FAST_CMPA);
  wire logic phase_tgl_ok = (wave_mode_sel == twoc_pkg::MODE_PFC_CMPA) | (wave_mode_sel == twoc_pkg::MODE_PC_CMPA);

  // Each channel keeps its own level; the pin owner and the driver
  // enable come from the same decode, so they never disagree.
  // Limitation: in the phase modes a compare value at TOP is not treated
  // on its own; such a match acts like any other match.
  // Trade-off: when a match and BOTTOM land in one cycle in fast PWM,
  // the match action is kept and the BOTTOM action is dropped.
  // A disconnected channel holds its level, so reconnecting it does not
  // replay stale events.
  // Per-channel waveform logic
  logic [1:0] nxt_wave;
  logic [1:0] nxt_ovr;
  logic [1:0] nxt_pin_oe;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      // Inputs of this channel, picked by the loop index
      wire logic [1:0] om = outmode[ch];
      wire logic is_tgl = om == twoc_pkg::OM_TOGGLE;
      wire logic mtch = CNT_EVT_IN.match[ch];
      wire logic at_top = CNT_EVT_IN.cmp_eq_top[ch];
      // Toggle allowed: always in non-PWM, only channel A in listed PWM modes
      wire logic tgl_ok = fam_nonpwm | ((ch == 0) & ((fam_fast & fast_tgl_ok) | (fam_phase & phase_tgl_ok))); // [RULE_06] [RULE_09]
      // Pin is taken over only when the field selects a real action
      wire logic conn = (om != twoc_pkg::OM_OFF) & ~(is_tgl & ~tgl_ok) & (nxt_mode.family != twoc_pkg::FAM_RSVD); // [RULE_01]
      // Match is ignored in fast PWM when compare sits at TOP with high bit set
      wire logic fast_mtch = mtch & ~(at_top & om[1]); // [RULE_07]
      // Channel B needs port D bit two unless the modulator carries it
      wire logic drv_gate = (ch == 0) | MODULATOR_EN_IN | PORT_D_BIT_TWO_IN; // [RULE_03]

      // Next level of the compare output
      always_comb begin
        nxt_wave[ch] = wave_ff[ch];
        // Toggle only where the mode allows it
        if (conn & is_tgl) begin
          if (mtch) begin
            nxt_wave[ch] = ~wave_ff[ch]; // [RULE_04] [RULE_06] [RULE_09]
          end
        end else if (conn & fam_nonpwm) begin
          // Low bit gives the level on a match
          if (mtch) begin
            nxt_wave[ch] = om[0]; // [RULE_04]
          end
        end else if (conn & fam_fast) begin
          // Match wins over bottom when both land together
          if (fast_mtch) begin
            nxt_wave[ch] = om[0]; // [RULE_05]
          end else if (CNT_EVT_IN.at_bottom) begin
            nxt_wave[ch] = ~om[0]; // [RULE_05] [RULE_07]
          end
        end else if (conn & fam_phase) begin
          // Counting direction picks set or clear
          if (mtch) begin
            nxt_wave[ch] = CNT_EVT_IN.count_up ? om[0] : ~om[0]; // [RULE_08]
          end
        end
      end

      // Override and driver enable, the direction bit gates the driver
      assign nxt_ovr[ch] = conn; // [RULE_01]
      assign nxt_pin_oe[ch] = PORT_DIR_IN[ch] & (~conn | drv_gate); // [RULE_02]
    end
  endgenerate

  // Pin level: compare output when taken over, else port data
  // Port data passes through unchanged while a channel is disconnected
  wire logic [1:0] nxt_pin = (nxt_ovr & nxt_wave) | (~nxt_ovr & PORT_DATA_IN); // [RULE_01]

  // Read mux, unmapped words read zero
  // Status shows the live family and the registered pin state
  // Reads have no side effects, so a repeated read is harmless
  wire logic [7:0] status_val = {1'b0, nxt_mode.family, ovr_ff, wave_ff};
  wire logic [7:0] rd_byte = hit_a ? wave_ctrl_a_ff
                            : hit_b ? wave_ctrl_b_ff
                            : hit_st ? status_val
                            : 8'h00;
  wire logic [31:0] nxt_rdata = {24'h000000, rd_byte};

  // Control registers, written only on the acknowledging access
  // A write lands on the edge that takes the request
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      // Timer stopped, pins released
      wave_ctrl_a_ff <= twoc_pkg::CTRL_RST;
      wave_ctrl_b_ff <= twoc_pkg::CTRL_RST;
    end else begin
      if (wr_a) begin
        wave_ctrl_a_ff <= nxt_wave_ctrl_a;
      end
      if (wr_b) begin
        wave_ctrl_b_ff <= nxt_wave_ctrl_b;
      end
    end
  end

  // Bus answer: one wait state, ack for one cycle
  // Fixed latency keeps the master simple; ack drops in the next cycle
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      // Idle bus after reset
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_req;
      if (bus_req) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // Wave state and pin outputs
  // Pin level uses the new wave level, so pin and compare output agree
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      // Compare outputs low, pins released
      wave_ff <= 2'h0;
      ovr_ff <= 2'h0;
      pin_ff <= 2'h0;
      pin_oe_ff <= 2'h0;
    end else begin
      // All four load together every cycle
      wave_ff <= nxt_wave;
      ovr_ff <= nxt_ovr;
      pin_ff <= nxt_pin;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  // Decoded mode, registered so the datapath sees clean levels
  // Costs one cycle of lag after a control write
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      // Normal mode with the full-range TOP
      mode_info_ff <= '{family: twoc_pkg::FAM_NORMAL, top_src: twoc_pkg::TSRC_FIXED,
                        top_fixed: twoc_pkg::TOP_MAX, upd_at: twoc_pkg::PT_IMMED,
                        ovf_at: twoc_pkg::PT_MAX};
    end else begin
      mode_info_ff <= nxt_mode;
    end
  end

  // Clock select is stored only; the prescaler lives elsewhere
  // Copied with one cycle of lag, like the mode
  logic [2:0] clk_sel_ff;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      // No clock source after reset
      clk_sel_ff <= 3'h0;
    end else begin
      clk_sel_ff <= wave_ctrl_b_ff[twoc_pkg::B_CS_HI:twoc_pkg::B_CS_LO];
    end
  end

  // Outputs straight from flip-flops
  // No logic between the registers and the ports
  assign WB_ACK_OUT = ack_ff;
  assign WB_DAT_OUT = rdata_ff;
  assign MODE_INFO_OUT = mode_info_ff;
  assign CLK_SEL_OUT = clk_sel_ff;
  assign CMP_OUT_OUT = wave_ff;
  assign PIN_OVR_OUT = ovr_ff;
  assign PIN_OUT = pin_ff;
  assign PIN_OE_OUT = pin_oe_ff;

endmodule : twoc_wave_ctrl
`default_nettype wire

// *** twoc_wave_ctrl_props.sv ***
`default_nettype none
module twoc_wave_ctrl_props (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // Register bus
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  // Port settings
  input wire logic [1:0] PORT_DIR_IN,
  input wire logic PORT_D_BIT_TWO_IN,
  input wire logic MODULATOR_EN_IN,
  // Block outputs
  input wire twoc_pkg::twoc_mode_t MODE_INFO_OUT,
  input wire logic [1:0] CMP_OUT_OUT,
  input wire logic [1:0] PIN_OVR_OUT,
  input wire logic [1:0] PIN_OUT,
  input wire logic [1:0] PIN_OE_OUT
);
  // Short names for the decoded fields
  wire twoc_pkg::twoc_family_t fam = MODE_INFO_OUT.family;
  wire twoc_pkg::twoc_point_t upd = MODE_INFO_OUT.upd_at;
  wire twoc_pkg::twoc_point_t ovf = MODE_INFO_OUT.ovf_at;
  // One clock domain, so one default for all
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  ack_answer_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("no ack one cycle after a request");
  ack_single_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  rdata_upper_a: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  pin_follow_a: assert property ((PIN_OUT & PIN_OVR_OUT) == (CMP_OUT_OUT & PIN_OVR_OUT))
    else $error("overridden pin differs from compare output");
  oe_dir_a: assert property ((PIN_OE_OUT & ~$past(PORT_DIR_IN)) == 2'h0)
    else $error("pin driven without direction bit");
  b_gate_a: assert property (PIN_OE_OUT[1] && PIN_OVR_OUT[1] |->
    $past(PORT_D_BIT_TWO_IN) || $past(MODULATOR_EN_IN)) else $error("channel B driven without enable");
  b_hold_a: assert property (!PIN_OVR_OUT[1] |-> $stable(CMP_OUT_OUT[1]))
    else $error("disconnected channel B changed level");
  normal_dec_a: assert property (fam == twoc_pkg::FAM_NORMAL |-> ovf == twoc_pkg::PT_MAX &&
    MODE_INFO_OUT.top_fixed == twoc_pkg::TOP_MAX) else $error("normal mode decode wrong");
  fast_dec_a: assert property (fam == twoc_pkg::FAM_FAST |-> upd == twoc_pkg::PT_BOTTOM &&
    ovf == twoc_pkg::PT_TOP) else $error("fast mode points wrong");
  pfc_dec_a: assert property (fam == twoc_pkg::FAM_PFC |-> upd == twoc_pkg::PT_BOTTOM &&
    ovf == twoc_pkg::PT_BOTTOM) else $error("phase-frequency points wrong");
endmodule : twoc_wave_ctrl_props
`default_nettype wire

// *** twoc_port_model.sv ***
`default_nettype none
module twoc_port_model (
  // Software port settings
  input wire logic [1:0] dir_in,
  input wire logic d2_in,
  // Drivers from the compare block
  input wire logic [1:0] pin_in,
  input wire logic [1:0] oe_in,
  // Towards the block and the pads
  output logic [1:0] dir_out,
  output logic d2_out,
  output logic [1:0] pad_out
);
  // Direction and data bit pass straight on
  assign dir_out = dir_in;
  assign d2_out = d2_in;
  // Undriven pad floats up to the pull-up, never to the last value
  assign pad_out = (oe_in & pin_in) | ~oe_in;
endmodule : twoc_port_model
`default_nettype wire

// *** twoc_wave_ctrl_test.sv ***
`default_nettype none
module twoc_wave_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Byte addresses, four times the word index
  localparam logic [9:0] AD_A = {twoc_pkg::IDX_CTRL_A, 2'h0};
  localparam logic [9:0] AD_B = {twoc_pkg::IDX_CTRL_B, 2'h0};
  localparam logic [9:0] AD_S = {twoc_pkg::IDX_STATUS, 2'h0};
  // Expected decode, one nibble per mode, mode 0 lowest
  localparam logic [63:0] FAM_T = 64'h2251_3344_2221_3330;
  localparam logic [63:0] SRC_T = 64'h1202_1212_0001_0000;
  localparam logic [63:0] UPD_T = 64'h2200_1122_2220_1110;
  localparam logic [63:0] OVF_T = 64'h1103_2222_1113_2223;
  // Bench signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [5:0] evt = 6'h0;
  logic [1:0] dir = 2'h0;
  logic d2 = 1'b0;
  logic [1:0] pdat = 2'h0;
  logic mod = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [1:0] dir_p, cmp, ovr, pin, oe, pad;
  logic d2_p;
  twoc_pkg::twoc_mode_t mi;
  logic [2:0] csel;
  int mismatches = 0;
  int cmp_count = 0;
  always #4 clk = ~clk;
  twoc_wave_ctrl i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(cyc),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .CNT_EVT_IN(evt), .PORT_DATA_IN(pdat), .PORT_DIR_IN(dir_p),
    .PORT_D_BIT_TWO_IN(d2_p), .MODULATOR_EN_IN(mod), .MODE_INFO_OUT(mi), .CLK_SEL_OUT(csel),
    .CMP_OUT_OUT(cmp), .PIN_OVR_OUT(ovr), .PIN_OUT(pin), .PIN_OE_OUT(oe));
  twoc_port_model i_port (.dir_in(dir), .d2_in(d2), .pin_in(pin), .oe_in(oe),
    .dir_out(dir_p), .d2_out(d2_p), .pad_out(pad));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One classic cycle, held until ack is sampled
  task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 8'h0, r);
    check("rdata", r, e);
  endtask : rd
  // Both control registers, then let outputs settle
  task automatic cfg(input logic [7:0] a, input logic [7:0] b);
    wr(AD_A, a);
    wr(AD_B, b);
    repeat (2) @(posedge clk);
    #1;
  endtask : cfg
  // One event cycle, then compare levels
  task automatic ev(input logic [5:0] v, input logic [1:0] e);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= {1'b0, v[4], 4'h0};
    #1;
    check("cmp_out", cmp, e);
  endtask : ev
  task automatic t_regs();
    rd(AD_A, 32'h0);
    rd(AD_B, 32'h0);
    wr(AD_A, 8'hff);
    rd(AD_A, 32'hf3);
    @(posedge clk);
    sel <= 4'he;
    wr(AD_A, 8'h00);
    rd(AD_A, 32'hf3);
    @(posedge clk);
    sel <= 4'hf;
    wr(AD_B, 8'hff);
    rd(AD_B, 32'hdf);
    wr(10'h3fc, 8'hff);
    rd(10'h3fc, 32'h0);
    cfg(8'h00, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_modes();
    for (int m = 0; m < 16; m++) begin
      logic [15:0] t;
      t = (m == 0) ? 16'hffff : (m[1:0] == 2'h1) ? 16'h00ff : (m[1:0] == 2'h2) ? 16'h01ff : 16'h03ff;
      if (m != 13) begin
        cfg({6'h0, m[1:0]}, {3'h0, m[3:2], 3'h5});
        check("family", mi.family, FAM_T[4*m+:3]);
        check("top_src", mi.top_src, SRC_T[4*m+:2]);
        check("upd_at", mi.upd_at, UPD_T[4*m+:2]);
        check("ovf_at", mi.ovf_at, OVF_T[4*m+:2]);
        if (SRC_T[4*m+:2] == 2'h0) check("top", mi.top_fixed, t);
        check("clk_sel", csel, 3'h5);
        rd(AD_S, {25'h0, FAM_T[4*m+:3], 4'h0});
      end
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_plain();
    @(posedge clk);
    dir <= 2'h3;
    d2 <= 1'b1;
    pdat <= 2'h3;
    cfg(8'hd0, 8'h00);
    ev(6'h0c, 2'h3);
    check("override", ovr, 2'h3);
    cfg(8'h80, 8'h00);
    ev(6'h0c, 2'h2);
    check("override", ovr, 2'h1);
    check("pad_a", pad[0], 1'b0);
    check("pin", pin, 2'h2);
    @(posedge clk);
    dir <= 2'h0;
    cfg(8'hb0, 8'h00);
    check("oe", oe, 2'h0);
    @(posedge clk);
    dir <= 2'h3;
    d2 <= 1'b0;
    cfg(8'hb0, 8'h00);
    check("oe", oe, 2'h1);
    @(posedge clk);
    mod <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("oe", oe, 2'h3);
    @(posedge clk);
    mod <= 1'b0;
    d2 <= 1'b1;
    $display("test plain done");
  endtask : t_plain
  task automatic t_fast();
    cfg(8'hb2, 8'h18);
    ev(6'h20, 2'h1);
    ev(6'h0c, 2'h2);
    ev(6'h0f, 2'h2);
    ev(6'h23, 2'h1);
    cfg(8'h52, 8'h18);
    ev(6'h0c, 2'h0);
    check("override", ovr, 2'h1);
    cfg(8'h51, 8'h08);
    check("override", ovr, 2'h0);
    check("pin", pin, 2'h3);
    $display("test fast done");
  endtask : t_fast
  task automatic t_phase();
    cfg(8'hb3, 8'h10);
    ev(6'h1c, 2'h2);
    ev(6'h0c, 2'h1);
    cfg(8'h51, 8'h10);
    ev(6'h0c, 2'h0);
    check("override", ovr, 2'h1);
    cfg(8'h52, 8'h10);
    check("override", ovr, 2'h0);
    $display("test phase done");
  endtask : t_phase
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_plain();
    t_fast();
    t_phase();
    give_verdict();
  end
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule : twoc_wave_ctrl_test
bind twoc_wave_ctrl twoc_wave_ctrl_props i_props (.CLK_IN, .SYS_RST_IN, .WB_CYC_IN, .WB_STB_IN,
  .WB_DAT_OUT, .WB_ACK_OUT, .PORT_DIR_IN, .PORT_D_BIT_TWO_IN, .MODULATOR_EN_IN, .MODE_INFO_OUT,
  .CMP_OUT_OUT, .PIN_OVR_OUT, .PIN_OUT, .PIN_OE_OUT);
`default_nettype wire
